//--- half_bridge_spi_control_tb_top.sv
`timescale 1ns/1ps
module half_bridge_spi_control_tb_top import hbs_pkg::*; ;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [11:0] oc_fault = 12'h000;
   logic [11:0] ul_fault = 12'h000;
   logic uv_fault = 1'b0;
   logic ov_fault = 1'b0;
   logic thermal_warn = 1'b0;
   logic thermal_sd = 1'b0;
   logic [11:0] bridge_drive, bridge_side, drive_b;
   logic sleep, ready, sleep_b, ready_b;
   logic [31:0] rd;
   int err_total = 0;
   int checked = 0;
   // clear spacing scaled down from 150 us so the run stays short
   localparam int SRR_GAP_TB = 600;
   hbs_link_if link();
   hbs_link_if link_b();
   always #12.5 core_clk = ~core_clk;
   hbs_host #(.SRR_GAP_CYCLES(SRR_GAP_TB), .GAP_CYCLES(4), .HALF_CYCLES(8)) i_hbs_host (
      .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link.host));
   hbs_device #(.POR_CYCLES(8)) i_hbs_device (
      .core_clk(core_clk), .reset(reset), .link(link.dev), .oc_fault(oc_fault),
      .ul_fault(ul_fault), .uv_fault(uv_fault), .ov_fault(ov_fault),
      .thermal_warn(thermal_warn), .thermal_sd(thermal_sd), .bridge_drive(bridge_drive),
      .bridge_side(bridge_side), .sleep(sleep), .ready(ready));
   // second device on a link driven by the bench, for malformed frames
   hbs_device #(.POR_CYCLES(8)) i_hbs_device_b (
      .core_clk(core_clk), .reset(reset), .link(link_b.dev), .oc_fault(oc_fault),
      .ul_fault(ul_fault), .uv_fault(uv_fault), .ov_fault(ov_fault),
      .thermal_warn(thermal_warn), .thermal_sd(thermal_sd), .bridge_drive(drive_b),
      .bridge_side(), .sleep(sleep_b), .ready(ready_b));
   hbs_properties i_hbs_properties (
      .core_clk(core_clk), .reset(reset), .en(link.en), .cs_n(link.cs_n), .sclk(link.sclk),
      .sdi(link.sdi), .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));
   task wrap_up;
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task give_up(input bit hit);
      if (hit) begin
         err_total++;
         $display("mismatch at %0t: wait ran out", $time);
         wrap_up();
      end
   endtask
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 5000);
      rd = avs_readdata;
      give_up(n >= 5000);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // wait until the host is idle and the command has landed
   task idle_wait;
      int n;
      n = 0;
      do begin
         av(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end while (rd[STS_BUSY] !== 1'b0 && n < 500);
      give_up(n >= 500);
      repeat (8) @(posedge core_clk);
   endtask
   // one command frame
   task frame(input logic [15:0] cmd);
      av(1'b1, REG_COMMAND, {16'h0000, cmd});
      idle_wait();
   endtask
   task wait_ready(input bit b);
      int n;
      n = 0;
      while ((b ? ready_b : ready) !== 1'b1 && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      give_up(n >= 500);
   endtask
   task bb_frame(input logic [31:0] w, input int nb);
      @(posedge core_clk);
      link_b.cs_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      for (int i = nb - 1; i >= 0; i--) begin
         link_b.sclk <= 1'b1;
         link_b.sdi <= w[i];
         repeat (4) @(posedge core_clk);
         link_b.sclk <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      link_b.cs_n <= 1'b1;
      link_b.sdi <= 1'b0;
      repeat (210) @(posedge core_clk);
   endtask
   task t_reset;
      chk(32'(bridge_drive), 32'h0000_0000, "drive at reset");
      chk(32'(sleep), 32'h0000_0001, "sleep at reset");
      av(1'b0, REG_RESPONSE, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "status at reset");
      av(1'b1, 4'h2, 32'h0000_ABCD);
      av(1'b0, 4'h2, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read");
      $display("test reset done");
   endtask
   task t_enable;
      av(1'b1, REG_ENABLE, 32'h0000_0001);
      wait_ready(1'b0);
      chk(32'(sleep), 32'h0000_0000, "awake");
      av(1'b0, REG_STATUS, 32'h0000_0000);
      chk(32'(rd[STS_LINK_EN]), 32'h0000_0001, "enable bit");
      $display("test enable done");
   endtask
   task t_groups;
      frame(16'h1FD4);
      chk(32'(bridge_drive[5:0]), 32'h0000_003F, "lower drive");
      chk(32'(bridge_side[5:0]), 32'h0000_002A, "lower side");
      frame(16'h562B);
      chk(32'(bridge_drive), 32'h0000_0B3F, "upper drive");
      chk(32'(bridge_side[11:6]), 32'h0000_0015, "upper side");
      av(1'b0, REG_RESPONSE, 32'h0000_0000);
      chk(rd, 32'h0000_1FFE, "lower status");
      $display("test groups done");
   endtask
   task t_faults;
      oc_fault <= 12'h002;
      ul_fault <= 12'h001;
      thermal_warn <= 1'b1;
      frame(16'h3FD4);
      frame(16'h3FD4);
      av(1'b0, REG_RESPONSE, 32'h0000_0000);
      chk(rd, {16'h0000, 3'b101, 8'hFF, CODE_OC, CODE_ULD, 1'b1}, "fault status");
      chk(32'(bridge_drive[1:0]), 32'h0000_0000, "faulted off");
      oc_fault <= 12'h000;
      ul_fault <= 12'h000;
      thermal_warn <= 1'b0;
      frame(16'hBFD4);
      frame(16'h3FD4);
      chk(32'(bridge_drive[1:0]), 32'h0000_0003, "reprogrammed");
      av(1'b0, REG_RESPONSE, 32'h0000_0000);
      chk(32'(rd[15:13]), 32'h0000_0000, "flags cleared");
      $display("test faults done");
   endtask
   task t_tsd;
      thermal_sd <= 1'b1;
      frame(16'h3FD4);
      av(1'b0, REG_STATUS, 32'h0000_0000);
      chk(32'(rd[STS_TSD]), 32'h0000_0001, "prefix set");
      chk(32'(bridge_drive), 32'h0000_0000, "shut down");
      thermal_sd <= 1'b0;
      frame(16'hBFD4);
      frame(16'h3FD4);
      av(1'b0, REG_STATUS, 32'h0000_0000);
      chk(32'(rd[STS_TSD]), 32'h0000_0000, "prefix cleared");
      $display("test thermal done");
   endtask
   task t_overvoltage_lockout_enable;
      ov_fault <= 1'b1;
      frame(16'h1FD5);
      frame(16'h1FD5);
      av(1'b0, REG_RESPONSE, 32'h0000_0000);
      chk(32'(rd[ST_SUPPLY]), 32'h0000_0001, "supply fault");
      chk(32'(bridge_drive), 32'h0000_0000, "locked out");
      ov_fault <= 1'b0;
      $display("test lockout done");
   endtask
   task t_gap;
      longint t0;
      av(1'b1, REG_COMMAND, 32'h0000_8000);
      t0 = $time;
      // a second clear request must be held off for the whole spacing
      av(1'b1, REG_COMMAND, 32'h0000_8000);
      chk(32'($time - t0 >= 25 * SRR_GAP_TB), 32'h0000_0001, "clear spacing");
      idle_wait();
      $display("test clear spacing done");
   endtask
   task t_sleep;
      av(1'b1, REG_ENABLE, 32'h0000_0000);
      repeat (10) @(posedge core_clk);
      chk(32'(sleep), 32'h0000_0001, "asleep");
      av(1'b1, REG_ENABLE, 32'h0000_0001);
      wait_ready(1'b0);
      chk(32'(bridge_drive), 32'h0000_0000, "cleared by sleep");
      $display("test sleep done");
   endtask
   task t_bad;
      link_b.en <= 1'b1;
      wait_ready(1'b1);
      bb_frame(32'h0000_1FD4, 16);
      chk(32'(drive_b[5:0]), 32'h0000_003F, "good frame");
      bb_frame(32'h0000_0000, 15);
      bb_frame(32'h0000_0000, 0);
      chk(32'(drive_b[5:0]), 32'h0000_003F, "short frames dropped");
      bb_frame(32'h0000_0F80, 32);
      chk(32'(drive_b[5:0]), 32'h0000_001F, "last word kept");
      link_b.en <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk(32'(drive_b), 32'h0000_0000, "disable clears");
      chk(32'(sleep_b), 32'h0000_0001, "second asleep");
      $display("test frame errors done");
   endtask
   initial begin
      link_b.en = 1'b0;
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.sdi = 1'b0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_enable();
      t_groups();
      t_faults();
      t_tsd();
      t_overvoltage_lockout_enable();
      t_gap();
      t_sleep();
      t_bad();
      wrap_up();
   end
endmodule

//--- hbs_device.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module hbs_device import hbs_pkg::*; #(
   parameter int POR_CYCLES = POR_CYC
) (
   input wire logic core_clk,                // system clock
   input wire logic reset,                   // synchronous, active high
   hbs_link_if.dev link,                     // serial link
   input wire logic [BRIDGES-1:0] oc_fault,  // overcurrent seen per bridge
   input wire logic [BRIDGES-1:0] ul_fault,  // underload seen per bridge
   input wire logic uv_fault,                // supply undervoltage
   input wire logic ov_fault,                // supply overvoltage
   input wire logic thermal_warn,            // thermal warning level
   input wire logic thermal_sd,              // thermal shutdown level
   output logic [BRIDGES-1:0] bridge_drive,  // bridge actively driven
   output logic [BRIDGES-1:0] bridge_side,   // 1 high side on, 0 low side on
   output logic sleep,                       // low-power state
   output logic ready                        // power-on delay finished
);
   function automatic logic [1:0] bridge_code(input logic oc, input logic ul, input logic on);
      if (oc) begin
         return CODE_OC;
      end else if (ul) begin
         return CODE_ULD;
      end else if (on) begin
         return CODE_ON;
      end
      return CODE_OFF;
   endfunction

   logic [1:0] en_s;
   logic [1:0] cs_s;
   logic [1:0] sck_s;
   logic [1:0] sdi_s;
   logic cs_d;
   logic sck_d;
   logic clr;
   logic [15:0] por_cnt;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic in_frame;
   logic any_rise;
   logic [3:0] bit_cnt;
   logic [FRAME_BITS-1:0] shreg;
   logic commit;
   logic [FRAME_BITS-1:0] cmd_upper;
   logic [FRAME_BITS-1:0] cmd_lower;
   logic last_group;
   logic overvoltage_lockout_enable_en;
   logic clear_req;
   logic clear_group;
   logic [BRIDGES-1:0] clr_mask;
   logic [BRIDGES-1:0] oc_lat;
   logic [BRIDGES-1:0] uld_lat;
   logic tsd_lat;
   logic supply_fault;
   logic [BRIDGES-1:0] uld_shut;
   logic [BRIDGES-1:0] next_drive;
   logic [FRAME_BITS-1:0] status_word;

   // only the second stage of each synchroniser is read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         en_s <= 2'h0;
         cs_s <= 2'h3;
         sck_s <= 2'h0;
         sdi_s <= 2'h0;
         cs_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         en_s <= {en_s[0], link.en};
         cs_s <= {cs_s[0], link.cs_n};
         sck_s <= {sck_s[0], link.sclk};
         sdi_s <= {sdi_s[0], link.sdi};
         cs_d <= cs_s[1];
         sck_d <= sck_s[1];
      end
   end

   assign clr = reset | ~en_s[1];
   assign sck_rise = sck_s[1] & ~sck_d;
   assign sck_fall = ~sck_s[1] & sck_d;
   assign cs_fall = cs_d & ~cs_s[1];
   assign cs_rise = ~cs_d & cs_s[1];

   // power-on delay after enable rises; serial traffic ignored until done
   always_ff @(posedge core_clk) begin
      if (clr) begin
         por_cnt <= 16'h0000;
         ready <= 1'b0;
      end else if (!ready) begin
         por_cnt <= por_cnt + 16'h0001;
         ready <= (por_cnt == 16'(POR_CYCLES - 1));
      end
   end

   always_ff @(posedge core_clk) begin
      sleep <= clr;
   end

   always_ff @(posedge core_clk) begin
      if (clr || !ready) begin
         shreg <= STATUS_RESET;
         bit_cnt <= 4'h0;
         any_rise <= 1'b0;
         in_frame <= 1'b0;
         link.sdo <= 1'b0;
         link.sdo_oe_n <= 1'b1;
      end else if (cs_fall) begin
         shreg <= status_word;
         link.sdo <= tsd_lat;
         link.sdo_oe_n <= 1'b0;
         in_frame <= 1'b1;
         bit_cnt <= 4'h0;
         any_rise <= 1'b0;
      end else if (cs_rise) begin
         link.sdo <= 1'b0;
         link.sdo_oe_n <= 1'b1;
         in_frame <= 1'b0;
      end else if (in_frame) begin
         if (sck_rise) begin
            link.sdo <= shreg[FRAME_BITS-1];
            bit_cnt <= bit_cnt + 4'h1;
            any_rise <= 1'b1;
         end
         if (sck_fall) begin
            // received bits push the status out, so the register ends
            // holding the last sixteen bits of the frame
            shreg <= {shreg[FRAME_BITS-2:0], sdi_s[1]};
         end
      end
   end

   assign commit = in_frame & cs_rise & any_rise & (bit_cnt == 4'h0);

   always_ff @(posedge core_clk) begin
      if (clr) begin
         cmd_upper <= CMD_RESET;
         cmd_lower <= CMD_RESET;
         last_group <= 1'b0;
         overvoltage_lockout_enable_en <= 1'b0;
         clear_req <= 1'b0;
         clear_group <= 1'b0;
      end else begin
         clear_req <= commit & shreg[CMD_CLEAR];
         if (commit) begin
            if (shreg[CMD_GROUP]) begin
               cmd_upper <= shreg;
            end else begin
               cmd_lower <= shreg;
            end
            last_group <= shreg[CMD_GROUP];
            clear_group <= shreg[CMD_GROUP];
            overvoltage_lockout_enable_en <= shreg[CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
         end
      end
   end

   always_comb begin
      clr_mask = '0;
      if (clear_req) begin
         if (clear_group) begin
            clr_mask[BRIDGES-1:GROUP_BRIDGES] = '1;
         end else begin
            clr_mask[GROUP_BRIDGES-1:0] = '1;
         end
      end
   end

   // an overcurrent or thermal shutdown still present wins over the clear, so the bridge stays off
   always_ff @(posedge core_clk) begin
      if (clr) begin
         oc_lat <= '0;
         uld_lat <= '0;
         tsd_lat <= 1'b0;
      end else begin
         oc_lat <= (oc_lat & ~clr_mask) | oc_fault;
         uld_lat <= (uld_lat & ~clr_mask) | (ul_fault & bridge_drive);
         tsd_lat <= (tsd_lat & ~clear_req) | thermal_sd;
      end
   end

   assign supply_fault = uv_fault | (ov_fault & overvoltage_lockout_enable_en);
   assign uld_shut = {{GROUP_BRIDGES{cmd_upper[CMD_ULD_SHUT]}},
                      {GROUP_BRIDGES{cmd_lower[CMD_ULD_SHUT]}}};

   always_comb begin
      next_drive = {cmd_upper[CMD_EN_LO +: GROUP_BRIDGES],
                    cmd_lower[CMD_EN_LO +: GROUP_BRIDGES]};
      next_drive = next_drive & ~oc_lat & ~(uld_lat & uld_shut);
      if (supply_fault || tsd_lat) begin
         next_drive = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         bridge_drive <= '0;
         bridge_side <= '0;
      end else begin
         bridge_drive <= next_drive;
         bridge_side <= {cmd_upper[CMD_SIDE_LO +: GROUP_BRIDGES],
                         cmd_lower[CMD_SIDE_LO +: GROUP_BRIDGES]};
      end
   end

   always_comb begin
      logic [GROUP_BRIDGES-1:0] g_oc;
      logic [GROUP_BRIDGES-1:0] g_ul;
      logic [GROUP_BRIDGES-1:0] g_on;
      g_oc = last_group ? oc_lat[BRIDGES-1:GROUP_BRIDGES] : oc_lat[GROUP_BRIDGES-1:0];
      g_ul = last_group ? uld_lat[BRIDGES-1:GROUP_BRIDGES] : uld_lat[GROUP_BRIDGES-1:0];
      g_on = last_group ? bridge_drive[BRIDGES-1:GROUP_BRIDGES]
                        : bridge_drive[GROUP_BRIDGES-1:0];
      status_word = STATUS_RESET;
      status_word[ST_OC] = |g_oc;
      status_word[ST_SUPPLY] = supply_fault;
      status_word[ST_ULD] = |g_ul;
      status_word[ST_TW] = thermal_warn;
      for (int k = 0; k < GROUP_BRIDGES; k++) begin
         status_word[ST_CODE_LO + 2 * k +: 2] = bridge_code(g_oc[k], g_ul[k], g_on[k]);
      end
   end
endmodule

//--- hbs_host.sv
`timescale 1ns/1ps
module hbs_host import hbs_pkg::*; #(
   parameter int SRR_GAP_CYCLES = SRR_GAP_CYC,
   parameter int GAP_CYCLES = CSB_HIGH_CYC,
   parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
   input wire logic core_clk,          // system clock
   input wire logic reset,             // synchronous, active high
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read,          // read request
   input wire logic avs_write,         // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata,   // read data
   output logic avs_waitrequest,       // stall
   hbs_link_if.host link               // serial link
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_GAP} hbs_state_t;

   hbs_state_t state;
   logic [1:0] sdo_s;
   logic [15:0] cnt;
   logic [15:0] srr_cnt;
   logic [4:0] bit_cnt;
   logic [15:0] cmd_q;
   logic [15:0] last_cmd;
   logic [15:0] rx;
   logic [15:0] resp;
   logic tsd_bit;
   logic req;
   logic ok;
   logic take;
   logic start;
   logic [31:0] rd_mux;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sdo_s <= 2'h0;
      end else begin
         sdo_s <= {sdo_s[0], link.sdo_line};
      end
   end

   assign req = avs_read | avs_write;
   // a command waits for an idle link, a clear request also for the clear-request spacing
   assign ok = !(avs_write && avs_address == REG_COMMAND) ||
               (state == H_IDLE &&
                !(avs_writedata[CMD_CLEAR] && srr_cnt != 16'h0000));
   assign take = req & ~avs_waitrequest;
   assign start = take & avs_write & (avs_address == REG_COMMAND);

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         REG_COMMAND: rd_mux[15:0] = last_cmd;
         REG_STATUS: begin
            rd_mux[STS_BUSY] = (state != H_IDLE);
            rd_mux[STS_TSD] = tsd_bit;
            rd_mux[STS_LINK_EN] = link.en;
         end
         REG_RESPONSE: rd_mux[15:0] = resp;
         REG_ENABLE: rd_mux[0] = link.en;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest & ok);
         if (req && avs_waitrequest && ok) begin
            avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         link.en <= 1'b0;
      end else if (take && avs_write && avs_address == REG_ENABLE) begin
         link.en <= avs_writedata[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         srr_cnt <= 16'h0000;
      end else if (start && avs_writedata[CMD_CLEAR]) begin
         srr_cnt <= 16'(SRR_GAP_CYCLES);
      end else if (srr_cnt != 16'h0000) begin
         srr_cnt <= srr_cnt - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= H_IDLE;
         cnt <= 16'h0000;
         bit_cnt <= 5'h00;
         cmd_q <= 16'h0000;
         last_cmd <= 16'h0000;
         rx <= 16'h0000;
         resp <= 16'h0000;
         tsd_bit <= 1'b0;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.sdi <= 1'b0;
      end else begin
         cnt <= cnt + 16'h0001;
         unique case (state)
            H_IDLE: begin
               if (start) begin
                  cmd_q <= avs_writedata[15:0];
                  last_cmd <= avs_writedata[15:0];
                  bit_cnt <= 5'h00;
                  cnt <= 16'h0000;
                  link.cs_n <= 1'b0;
                  state <= H_SETUP;
               end
            end
            H_SETUP: begin
               // wait covers the select setup time and both synchronisers
               if (cnt == 16'(HALF_CYCLES - 1)) begin
                  tsd_bit <= sdo_s[1];
                  link.sclk <= 1'b1;
                  link.sdi <= cmd_q[15];
                  cmd_q <= {cmd_q[14:0], 1'b0};
                  cnt <= 16'h0000;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (cnt == 16'(HALF_CYCLES - 1)) begin
                  link.sclk <= 1'b0;
                  rx <= {rx[14:0], sdo_s[1]};
                  bit_cnt <= bit_cnt + 5'h01;
                  cnt <= 16'h0000;
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (cnt == 16'(HALF_CYCLES - 1)) begin
                  cnt <= 16'h0000;
                  if (bit_cnt == 5'(FRAME_BITS)) begin
                     link.cs_n <= 1'b1;
                     link.sdi <= 1'b0;
                     resp <= rx;
                     state <= H_GAP;
                  end else begin
                     link.sclk <= 1'b1;
                     link.sdi <= cmd_q[15];
                     cmd_q <= {cmd_q[14:0], 1'b0};
                     state <= H_HIGH;
                  end
               end
            end
            H_GAP: begin
               if (cnt == 16'(GAP_CYCLES - 1)) begin
                  state <= H_IDLE;
               end
            end
         endcase
      end
   end
endmodule

//--- hbs_link_if.sv
`timescale 1ns/1ps
interface hbs_link_if;
   logic en;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdo_oe_n;
   logic sdo_line;
   // released output reads low, like a pulled-down line
   assign sdo_line = sdo & ~sdo_oe_n;
   modport host (output en, output cs_n, output sclk, output sdi, input sdo_line);
   modport dev (input en, input cs_n, input sclk, input sdi, output sdo, output sdo_oe_n);
endinterface

//--- hbs_pkg.sv
// Notes on behaviour
// - every exchange is one full-duplex sixteen-bit frame
// - host holds enable high while talking
// - enable rise runs power-on delay, then serial ready
// - enable low clears state, drivers off, sleep
// - chip-select fall shows thermal-shutdown prefix bit
// - host keeps clock and data low before select
// - idle clock and data low; select low starts frame
// - input bits enter on rising clock, msb first
// - device samples input on the following falling edge
// - status leaves on rising clock, overcurrent first
// - select rise ends frame; output released
// - commit last sixteen bits only without frame error
// - bit 14 picks upper or lower bridge group
// - bit 15 clears latched faults of group
// - bit 13 enables underload shutdown for group
// - bits 12..7 enable bridges, highest first
// - bits 6..1 pick high or low side
// - bit 0 enables global overvoltage lockout
// - command bits zero after power-on reset
// - status word reports group of previous frame
// - bridge code: off, overcurrent, underload, enabled
// - status bits zero after power-on reset
// - host spaces clear requests by 150 us
package hbs_pkg;
   localparam int FRAME_BITS = 16;
   localparam int GROUP_BRIDGES = 6;
   localparam int BRIDGES = 12;
   // command field positions
   localparam int CMD_CLEAR = 15;
   localparam int CMD_GROUP = 14;
   localparam int CMD_ULD_SHUT = 13;
   localparam int CMD_EN_LO = 7;
   localparam int CMD_SIDE_LO = 1;
   localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
   // status field positions, reset values and bridge codes
   localparam int ST_OC = 15;
   localparam int ST_SUPPLY = 14;
   localparam int ST_ULD = 13;
   localparam int ST_CODE_LO = 1;
   localparam int ST_TW = 0;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [1:0] CODE_OFF = 2'h0;
   localparam logic [1:0] CODE_OC = 2'h1;
   localparam logic [1:0] CODE_ULD = 2'h2;
   localparam logic [1:0] CODE_ON = 2'h3;
   // timing
   localparam int CLK_MHZ = 40;
   localparam int POR_US = 100;
   localparam int SRR_GAP_US = 150;
   localparam int CSB_HIGH_US = 5;
   localparam int SELECT_SETUP_NS = 100;
   localparam int POR_CYC = POR_US * CLK_MHZ;
   localparam int SRR_GAP_CYC = SRR_GAP_US * CLK_MHZ;
   localparam int CSB_HIGH_CYC = CSB_HIGH_US * CLK_MHZ;
   localparam int SELECT_SETUP_CYC = (SELECT_SETUP_NS * CLK_MHZ + 999) / 1000;
   // 400 ns link period: leaves room for both synchronisers round trip
   localparam int SCLK_HALF_CYC = 8;
   // host register byte offsets and status register bit positions
   localparam logic [3:0] REG_COMMAND = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RESPONSE = 4'h8;
   localparam logic [3:0] REG_ENABLE = 4'hC;
   localparam int STS_BUSY = 0;
   localparam int STS_TSD = 1;
   localparam int STS_LINK_EN = 2;
endpackage

//--- hbs_properties.sv
`timescale 1ns/1ps
module hbs_properties (
   input wire logic core_clk, // system clock
   input wire logic reset,    // synchronous, active high
   input wire logic en,       // enable pin
   input wire logic cs_n,     // chip select
   input wire logic sclk,     // link clock
   input wire logic sdi,      // host data
   input wire logic sdo,      // device data
   input wire logic sdo_oe_n, // device output enable
   input wire logic sdo_line  // resolved device line
);
   logic [5:0] rise_cnt;
   logic sclk_q;
   always_ff @(posedge core_clk) begin
      sclk_q <= sclk;
   end
   // counts link clock rises inside a frame
   always_ff @(posedge core_clk) begin
      if (reset || cs_n) begin
         rise_cnt <= 6'h00;
      end else if (sclk && !sclk_q) begin
         rise_cnt <= rise_cnt + 6'h01;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_open; $fell(cs_n); endsequence
   sequence s_prefix; !sdo_oe_n && $stable(sdo_line); endsequence
   property p_frame_len; $rose(cs_n) |-> rise_cnt == 6'h10; endproperty
   property p_setup; s_open |-> !sclk [*4]; endproperty
   property p_prefix; s_open |-> ##6 s_prefix [*3]; endproperty
   property p_release; $rose(cs_n) |-> ##[1:5] sdo_oe_n; endproperty
   property p_quiet; cs_n [*5] |-> sdo_oe_n; endproperty
   property p_idle; cs_n |-> !sclk && !sdi; endproperty
   property p_launch; !cs_n && $changed(sdi) |-> $rose(sclk); endproperty
   property p_hold; $fell(sclk) |-> $stable(sdi) [*3]; endproperty
   property p_sleep; !en [*4] |-> sdo_oe_n; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame rise count not 16");
   a_setup: assert property (p_setup) else $error("clock too soon after select");
   a_prefix: assert property (p_prefix) else $error("prefix bit not held");
   a_release: assert property (p_release) else $error("output not released");
   a_quiet: assert property (p_quiet) else $error("output driven outside frame");
   a_idle: assert property (p_idle) else $error("clock or data high between frames");
   a_launch: assert property (p_launch) else $error("data moved off clock rise");
   a_hold: assert property (p_hold) else $error("data moved at clock fall");
   a_sleep: assert property (p_sleep) else $error("output driven while disabled");
endmodule
